// [rtl/hbpwm_map.svh]
// Notes on behaviour
// - a high-side short latches every bridge switch off until shutdown toggles or reset
// - high-side trip takes about 1530 cycles near 1.5x rated, faster at higher current
// - low-side current over limit blanks all switches for rest of the cycle
// - a logic level held on the limit input keeps the bridge shut down
// - A duty is fully off, about 25% to 75%, or fully on: the ramp dwells at each end
// - each polarity change passes through an interval with all four switches off
// - oscillator clock divided by two gives a square wave that steers the ramp
// - command above ramp drives A; command below ramp drives B
// - command outside the ramp span stops switching and holds one side on
// - dead time is a fixed cycle count, independent of switching frequency
// - both switches of one bridge leg are never on together
// - drive A turns on A-high and B-low; drive B turns on B-high and A-low
// - the clock input takes an external clock; clock output normally feeds it
// - the divider does not align ramp phase with other devices
`ifndef HBPWM_MAP_SVH
`define HBPWM_MAP_SVH

`define HBPWM_CLK_PERIOD_NS 40
`define HBPWM_DEAD_NS 400
`define HBPWM_DEAD_CYC ((`HBPWM_DEAD_NS + `HBPWM_CLK_PERIOD_NS - 1) / `HBPWM_CLK_PERIOD_NS)
`define HBPWM_OSC_HALF 9'h0FF
`define HBPWM_RAMP_MAX 8'hFF
`define HBPWM_RAMP_RST 8'h00
`define HBPWM_HS_RATED 8'h40
`define HBPWM_HS_TRIP 48960
`define HBPWM_SW_A_HI 0
`define HBPWM_SW_B_LO 1
`define HBPWM_SW_B_HI 2
`define HBPWM_SW_A_LO 3

`endif

// [rtl/hbpwm_pkg.sv]
package hbpwm_pkg;
    typedef logic [7:0] hbpwm_ramp_type;
    typedef logic signed [9:0] hbpwm_cmd_type;
    typedef logic [7:0] hbpwm_sense_type;
    typedef logic [3:0] hbpwm_dead_type;
    typedef logic [16:0] hbpwm_acc_type;
    typedef enum logic [3:0] {
        HBPWM_ST_OFF = 4'h1,
        HBPWM_ST_DEAD = 4'h2,
        HBPWM_ST_A = 4'h4,
        HBPWM_ST_B = 4'h8
    } hbpwm_state_type;
endpackage

// [rtl/hbpwm_ramp_if.sv]
`timescale 1ns/1ps
interface hbpwm_ramp_if;
    import hbpwm_pkg::*;
    hbpwm_ramp_type ramp;
    logic square;
    logic cycle_start;
    modport src (output ramp, output square, output cycle_start);
    modport snk (input ramp, input square, input cycle_start);
endinterface

// [rtl/hbpwm_ramp.sv]
`timescale 1ns/1ps
`include "hbpwm_map.svh"
module hbpwm_ramp (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic osc_in,
    hbpwm_ramp_if.src rif
);
    import hbpwm_pkg::*;

    logic osc_prev_q;
    logic square_q;
    logic start_q;
    hbpwm_ramp_type ramp_q;

    // free-running divider: phase against other devices is arbitrary
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev_q <= 1'b0;
            square_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_in;
            start_q <= 1'b0;
            if (osc_in && !osc_prev_q) begin
                square_q <= ~square_q;
                start_q <= ~square_q;
            end
        end
    end

    // square high ramps up, low ramps down; saturates at each end and holds until the square flips
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_q <= `HBPWM_RAMP_RST;
        end else if (square_q) begin
            if (ramp_q != `HBPWM_RAMP_MAX) begin
                ramp_q <= ramp_q + 8'h01;
            end
        end else if (ramp_q != `HBPWM_RAMP_RST) begin
            ramp_q <= ramp_q - 8'h01;
        end
    end

    assign rif.ramp = ramp_q;
    assign rif.square = square_q;
    assign rif.cycle_start = start_q;
endmodule

// [rtl/hbpwm_top.sv]
`timescale 1ns/1ps
`include "hbpwm_map.svh"
module hbpwm_top #(
    parameter int unsigned HS_TRIP = `HBPWM_HS_TRIP
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic shdn,
    input wire logic clk_in,
    input wire hbpwm_pkg::hbpwm_cmd_type cmd,
    input wire logic ilim,
    input wire hbpwm_pkg::hbpwm_sense_type hs_sense,
    output logic clk_out,
    output logic drv_a,
    output logic drv_b,
    output logic [3:0] sw_on,
    output logic hs_fault,
    output logic lim_active,
    output logic dead_active
);
    import hbpwm_pkg::*;

    localparam hbpwm_dead_type DEAD_LOAD = hbpwm_dead_type'(`HBPWM_DEAD_CYC - 1);
    localparam hbpwm_acc_type TRIP_LEVEL = hbpwm_acc_type'(HS_TRIP);
    localparam logic [3:0] SW_ON_A = 4'h3;

    hbpwm_ramp_if rif();

    logic [8:0] osc_cnt_q;
    logic clk_out_q;
    hbpwm_cmd_type cmd_q;
    hbpwm_cmd_type ramp_s;
    logic want_a;
    logic want_b;
    logic lim_q;
    logic shdn_prev_q;
    logic fault_q;
    hbpwm_acc_type acc_q;
    logic [17:0] acc_sum;
    logic inhibit;
    hbpwm_state_type state_q;
    hbpwm_state_type state_d;
    logic tgt_a_q;
    logic tgt_a_d;
    hbpwm_dead_type dead_q;
    hbpwm_dead_type dead_d;
    logic drv_a_q;
    logic drv_b_q;
    logic [3:0] sw_q;
    logic dead_act_q;

    hbpwm_ramp u_ramp (
        .clk(clk),
        .rst_n(rst_n),
        .osc_in(clk_in),
        .rif(rif.src)
    );

    // internal oscillator; the board normally loops clk_out back to clk_in
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_cnt_q <= 9'h000;
            clk_out_q <= 1'b0;
        end else if (osc_cnt_q == `HBPWM_OSC_HALF - 9'h001) begin
            osc_cnt_q <= 9'h000;
            clk_out_q <= ~clk_out_q;
        end else begin
            osc_cnt_q <= osc_cnt_q + 9'h001;
        end
    end

    // command sampled once per clock so the comparator sees a stable word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= 10'h000;
        end else begin
            cmd_q <= cmd;
        end
    end

    // equal values keep the present side, avoiding chatter at the crossing
    assign ramp_s = hbpwm_cmd_type'({2'b00, rif.ramp});
    assign want_a = cmd_q > ramp_s;
    assign want_b = cmd_q < ramp_s;

    // cycle-by-cycle limit; the set wins over the end-of-cycle clear
    // a level held on ilim simply keeps the latch set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lim_q <= 1'b0;
        end else begin
            lim_q <= ilim | (lim_q & ~rif.cycle_start);
        end
    end

    // integrate the excess over rated current: trip time falls as current rises
    assign acc_sum = {1'b0, acc_q} + 18'({1'b0, hs_sense} - {1'b0, `HBPWM_HS_RATED});

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= 17'h00000;
        end else if (shdn || hs_sense <= `HBPWM_HS_RATED) begin
            acc_q <= 17'h00000;
        end else if (acc_sum[17]) begin
            acc_q <= 17'h1FFFF;
        end else begin
            acc_q <= acc_sum[16:0];
        end
    end

    // latch holds through shutdown and clears only as shutdown releases
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shdn_prev_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            shdn_prev_q <= shdn;
            if (!shdn && acc_q >= TRIP_LEVEL) begin
                fault_q <= 1'b1;
            end else if (shdn_prev_q && !shdn) begin
                fault_q <= 1'b0;
            end
        end
    end

    assign inhibit = shdn | fault_q | lim_q | ilim;

    // every entry into a driven state passes through the dead interval
    always_comb begin
        state_d = state_q;
        tgt_a_d = tgt_a_q;
        dead_d = dead_q;
        case (state_q)
            HBPWM_ST_OFF: begin
                if (!inhibit && (want_a || want_b)) begin
                    state_d = HBPWM_ST_DEAD;
                    tgt_a_d = want_a;
                    dead_d = DEAD_LOAD;
                end
            end
            HBPWM_ST_DEAD: begin
                if (inhibit) begin
                    state_d = HBPWM_ST_OFF;
                end else if (dead_q != 4'h0) begin
                    dead_d = dead_q - 4'h1;
                end else begin
                    state_d = tgt_a_q ? HBPWM_ST_A : HBPWM_ST_B;
                end
            end
            HBPWM_ST_A: begin
                if (inhibit) begin
                    state_d = HBPWM_ST_OFF;
                end else if (want_b) begin
                    state_d = HBPWM_ST_DEAD;
                    tgt_a_d = 1'b0;
                    dead_d = DEAD_LOAD;
                end
            end
            HBPWM_ST_B: begin
                if (inhibit) begin
                    state_d = HBPWM_ST_OFF;
                end else if (want_a) begin
                    state_d = HBPWM_ST_DEAD;
                    tgt_a_d = 1'b1;
                    dead_d = DEAD_LOAD;
                end
            end
            default: begin
                state_d = HBPWM_ST_OFF;
            end
        endcase
    end

    // out-of-span commands never cross the ramp, so the side holds: 0% or 100%
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= HBPWM_ST_OFF;
            tgt_a_q <= 1'b0;
            dead_q <= 4'h0;
        end else begin
            state_q <= state_d;
            tgt_a_q <= tgt_a_d;
            dead_q <= dead_d;
        end
    end

    // outputs registered from the next state so they change with the state itself
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drv_a_q <= 1'b0;
            drv_b_q <= 1'b0;
            dead_act_q <= 1'b0;
        end else begin
            drv_a_q <= state_d == HBPWM_ST_A;
            drv_b_q <= state_d == HBPWM_ST_B;
            dead_act_q <= state_d == HBPWM_ST_DEAD;
        end
    end

    // one flop per switch; A and B are exclusive states, so no leg shoots through
    for (genvar i = 0; i < 4; i++) begin : g_sw
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                sw_q[i] <= 1'b0;
            end else if (SW_ON_A[i]) begin
                sw_q[i] <= state_d == HBPWM_ST_A;
            end else begin
                sw_q[i] <= state_d == HBPWM_ST_B;
            end
        end
    end

    assign clk_out = clk_out_q;
    assign drv_a = drv_a_q;
    assign drv_b = drv_b_q;
    assign sw_on = sw_q;
    assign hs_fault = fault_q;
    assign lim_active = lim_q;
    assign dead_active = dead_act_q;
endmodule

// [dv/hbpwm_asserts.sv]
`timescale 1ns/1ps
module hbpwm_asserts #(
    parameter int unsigned HS_TRIP = 320
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic shdn,
    input wire logic clk_in,
    input wire hbpwm_pkg::hbpwm_cmd_type cmd,
    input wire logic ilim,
    input wire hbpwm_pkg::hbpwm_sense_type hs_sense,
    input wire logic clk_out,
    input wire logic drv_a,
    input wire logic drv_b,
    input wire logic [3:0] sw_on,
    input wire logic hs_fault,
    input wire logic lim_active,
    input wire logic dead_active
);
    import hbpwm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_leg; !(sw_on[0] && sw_on[3]) && !(sw_on[1] && sw_on[2]); endproperty
    a_leg: assert property (p_leg) else $error("leg overlap");
    property p_map; sw_on == {drv_b, drv_b, drv_a, drv_a}; endproperty
    a_map: assert property (p_map) else $error("switch map");
    property p_dead; $rose(drv_a) || $rose(drv_b) |-> $past(dead_active); endproperty
    a_dead: assert property (p_dead) else $error("no dead gap");
    // an abort by limit or shutdown may end the gap early
    property p_dlen; $rose(dead_active) |-> (dead_active || ilim || shdn)[*8]; endproperty
    a_dlen: assert property (p_dlen) else $error("dead short");
    property p_shdn; shdn ##1 shdn |-> !drv_a && !drv_b; endproperty
    a_shdn: assert property (p_shdn) else $error("shdn drive");
    property p_lim; ilim |=> lim_active && !drv_a && !drv_b; endproperty
    a_lim: assert property (p_lim) else $error("limit drive");
    property p_latch; hs_fault && !$fell(shdn) |=> hs_fault; endproperty
    a_latch: assert property (p_latch) else $error("fault lost");
    property p_foff; hs_fault ##1 hs_fault |-> !drv_a && !drv_b; endproperty
    a_foff: assert property (p_foff) else $error("fault drive");
    property p_osc; $changed(clk_out) |=> $stable(clk_out)[*8]; endproperty
    a_osc: assert property (p_osc) else $error("osc short");
    c_a: cover property ($rose(drv_a));
    c_b: cover property ($rose(drv_b));
    c_f: cover property ($rose(hs_fault));
    c_l: cover property ($rose(lim_active));
endmodule
bind hbpwm_top hbpwm_asserts #(.HS_TRIP(HS_TRIP)) i_asserts (.clk(clk), .rst_n(rst_n),
    .shdn(shdn), .clk_in(clk_in), .cmd(cmd), .ilim(ilim), .hs_sense(hs_sense),
    .clk_out(clk_out), .drv_a(drv_a), .drv_b(drv_b), .sw_on(sw_on), .hs_fault(hs_fault),
    .lim_active(lim_active), .dead_active(dead_active));

// [dv/hbpwm_bridge.sv]
`timescale 1ns/1ps
module hbpwm_bridge (
    input wire logic [3:0] sw_on,
    input wire logic over_i,
    input wire logic lim_cmd,
    input wire hbpwm_pkg::hbpwm_sense_type short_lvl,
    output logic ilim,
    output hbpwm_pkg::hbpwm_sense_type hs_sense
);
    import hbpwm_pkg::*;
    // low-side sense only sees current through a conducting low switch
    assign ilim = lim_cmd || (over_i && (sw_on[1] || sw_on[3]));
    assign hs_sense = (sw_on[0] || sw_on[2]) ? short_lvl : 8'h20;
endmodule

// [dv/test_hbridge_pwm_control_with_fault_latch.sv]
`timescale 1ns/1ps
`include "hbpwm_map.svh"
module test_hbridge_pwm_control_with_fault_latch;
    import hbpwm_pkg::*;
    logic clk, rst_n, shdn, clk_in, ilim, clk_out, drv_a, drv_b, hs_fault, lim_active;
    logic dead_active;
    logic over_i, lim_cmd;
    logic [3:0] sw_on;
    hbpwm_cmd_type cmd;
    hbpwm_sense_type hs_sense, short_lvl;
    int fail_count, tests_run, cyc, na, nb, nd, e, n1, n2;
    int cmds[$] = '{-5, 0, 1, 64, 128, 200, 255, 256, 300};
    hbpwm_top #(.HS_TRIP(320)) i_dut (.clk(clk), .rst_n(rst_n), .shdn(shdn), .clk_in(clk_in),
        .cmd(cmd), .ilim(ilim), .hs_sense(hs_sense), .clk_out(clk_out), .drv_a(drv_a),
        .drv_b(drv_b), .sw_on(sw_on), .hs_fault(hs_fault), .lim_active(lim_active),
        .dead_active(dead_active));
    hbpwm_bridge i_bridge (.sw_on(sw_on), .over_i(over_i), .lim_cmd(lim_cmd),
        .short_lvl(short_lvl), .ilim(ilim), .hs_sense(hs_sense));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        #2;
        clk_in = clk_out;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out();
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(string what, int exp, int got);
        tests_run++;
        if (got != exp) begin
            fail_count++;
            $display("FAIL %s exp %0d got %0d", what, exp, got);
        end
    endtask
    // ramp of 1020 clk: up, hold high, down, hold low; a tie keeps the present side
    function automatic int exp_a(int c);
        int r, n, a, u;
        n = 0;
        a = 0;
        for (int t = 0; t < 2040; t++) begin
            u = t % 1020;
            r = u < 255 ? u + 1 : u < 510 ? 255 : u < 765 ? 764 - u : 0;
            if (c > r) begin
                a = 1;
            end else if (c < r) begin
                a = 0;
            end
            if (t >= 1020) begin
                n += a;
            end
        end
        return n;
    endfunction
    // slow steps keep the command far below the ramp slope
    task automatic slew(int tgt);
        while (int'(cmd) != tgt) begin
            repeat (4) @(posedge clk);
            #2 cmd = hbpwm_cmd_type'(int'(cmd) + (int'(cmd) < tgt ? 1 : -1));
        end
    endtask
    task automatic trip(input hbpwm_sense_type lvl, output int n);
        repeat (30) @(posedge clk);
        #2 short_lvl = lvl;
        n = 0;
        while (hs_fault !== 1'b1 && n < 200) begin
            @(posedge clk);
            #2 n++;
        end
        short_lvl = 8'h20;
        repeat (50) @(posedge clk);
        #2 chk("fault_hold", 1, int'(hs_fault === 1'b1 && drv_a === 1'b0));
        shdn = 1;
        repeat (3) @(posedge clk);
        #2 shdn = 0;
        repeat (3) @(posedge clk);
        #2 chk("fault_clear", 0, int'(hs_fault !== 1'b0));
    endtask
    initial begin
        clk = 0;
        rst_n = 0;
        shdn = 0;
        cmd = '0;
        over_i = 0;
        lim_cmd = 0;
        short_lvl = 8'h20;
        clk_in = 0;
        void'($urandom(32'hEE9523EA));
        cmds.push_back(2 + int'($urandom % 252));
        repeat (2) @(posedge clk);
        #2 rst_n = 1;
        foreach (cmds[i]) begin
            slew(cmds[i]);
            repeat (1020) @(posedge clk);
            na = 0;
            nb = 0;
            nd = 0;
            repeat (1020) begin
                @(posedge clk);
                #2 na += int'(drv_a === 1'b1);
                nb += int'(drv_b === 1'b1);
                nd += int'(dead_active === 1'b1);
            end
            e = exp_a(cmds[i]);
            if (e == 0 || e == 1020) begin
                chk("duty_a", e, na);
                chk("duty_b", 1020 - e, nb);
                chk("dead_idle", 0, nd);
            end else begin
                chk("dead_len", 2 * `HBPWM_DEAD_CYC, nd);
                chk("duty_a", e, (na - e <= 24 && e - na <= 24) ? e : na);
                chk("gap", 1, int'(na + nb <= 1000 && na + nb >= 980));
            end
        end
        slew(128);
        for (int k = 0; k < 1100 && drv_b !== 1'b1; k++) begin
            @(posedge clk);
            #2;
        end
        over_i = 1;
        repeat (2) @(posedge clk);
        #2 over_i = 0;
        chk("lim_hold", 1, int'(lim_active === 1'b1 && drv_b === 1'b0));
        lim_cmd = 1;
        repeat (1100) @(posedge clk);
        #2 chk("lim_level", 0, int'(drv_a !== 1'b0 || drv_b !== 1'b0));
        lim_cmd = 0;
        repeat (1100) @(posedge clk);
        #2 chk("lim_resume", 0, int'(lim_active !== 1'b0));
        slew(300);
        trip(8'h60, n1);
        trip(8'hA0, n2);
        chk("trip_order", 1, int'(n2 < n1 && n1 < 60));
        close_out();
    end
endmodule
